/* File: rtl/gdio_pkg.sv */
// shared constants and command codes for the general digital i/o port
package gdio_pkg;

    // port widths
    localparam int GEN_OUT_BITS = 8;
    localparam int WORD_BITS    = 16;
    localparam int EXT_BITS     = 32;
    localparam int IN_BITS      = 48;
    localparam int GEN_IN_BITS  = 16;
    localparam int AXES_MAX     = 8;
    localparam int AUX_BITS     = 16;
    localparam int ANA_CH       = 8;
    localparam int ANA_W        = 16;
    localparam int ADC_STD_BITS = 12;
    localparam int PC_W         = 16;
    localparam int IDX_W        = 7;
    localparam int DIR_BITS     = 4;
    localparam int SYNC_STAGES  = 2;

    // layout of the synchronised input vector
    localparam int SYNC_EXT_LSB = 16;
    localparam int SYNC_AUX_LSB = 48;
    localparam int SYNC_W       = 64;

    // variants with this many axes or more own outputs 9 to 16
    localparam int EXTRA_OUT_AXES = 5;

    // input and output index bounds
    localparam logic [6:0] IDX_MIN       = 7'h01;
    localparam logic [6:0] IDX_GEN_LAST  = 7'h08;
    localparam logic [6:0] IDX_WORD_LAST = 7'h10;
    localparam logic [6:0] IDX_EXT_FIRST = 7'h11;
    localparam logic [6:0] IDX_EXT_LAST  = 7'h30;
    localparam logic [6:0] IDX_AUX_FIRST = 7'h51;
    localparam logic [6:0] IDX_AUX_LAST  = 7'h60;

    // values after reset
    localparam logic [15:0] OUT_RST    = 16'h0000;
    localparam logic [31:0] EXT_RST    = 32'h0000_0000;
    localparam logic [3:0]  DIR_RST    = 4'h0;
    localparam logic [47:0] IRQ_EN_RST = 48'h0000_0000_0000;
    localparam logic [15:0] PC_RST     = 16'h0000;
    localparam logic [15:0] RD_RST     = 16'h0000;

    // software commands
    typedef enum logic [3:0] {
        OP_SET_BIT   = 4'h0,
        OP_CLR_BIT   = 4'h1,
        OP_COND_BIT  = 4'h2,
        OP_WORD_WR   = 4'h3,
        OP_DIR_CFG   = 4'h4,
        OP_READ_IN   = 4'h5,
        OP_WAIT_IN   = 4'h6,
        OP_IRQ_RANGE = 4'h7,
        OP_IRQ_MASK  = 4'h8,
        OP_IRQ_RET   = 4'h9,
        OP_STACK_CLR = 4'ha,
        OP_ANA_READ  = 4'hb
    } gdio_op_t;

endpackage

/* File: rtl/gdio_sync_if.sv */
// raw and synchronised external input vectors between port and synchroniser
`timescale 1ns/1ps
`default_nettype none
interface gdio_sync_if;
    import gdio_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] synced;
    modport src  (output raw, input synced);
    modport sync (input raw, output synced);
endinterface
`default_nettype wire

/* File: rtl/gdio_input_sync.sv */
// two-stage synchroniser for every external digital input
`timescale 1ns/1ps
`default_nettype none
module gdio_input_sync
    import gdio_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   nrst,
    gdio_sync_if.sync   bus
);
    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } gdio_sync_state_t;

    gdio_sync_state_t st;
    gdio_sync_state_t next_st;

    // first stage feeds only the second
    always_comb begin
        next_st        = st;
        next_st.stage1 = bus.raw;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.synced = st.stage2;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_sync_two_stage: assert property (
        nrst && $past(nrst) && $past(nrst, 2)
            |-> bus.synced == $past(bus.raw, 2))
        else $error("input not delayed by two stages");
endmodule
`default_nettype wire

/* File: rtl/gdio_port.sv */
// general digital i/o port: outputs, inputs, aux encoder, input irq, analog
`timescale 1ns/1ps
`default_nettype none
// How it works
// - eight dedicated outputs plus 32 points configurable as input or output
// - five to eight axis variants own eight more outputs, 9 to 16
// - set-bit drives one output high, clear-bit low, others untouched
// - conditional bit write drives high on non-zero value, low on zero
// - word write loads 16 bits at once, bit 0 is output 1; outputs 9 to 16 cleared below five axes
// - input read of index 1 to 48 returns that input's level
// - wait stalls until input high, or low for a negated index
// - each axis's aux encoder A and B readable as inputs 81 to 96
// - axis one A is input 81, B is 82, later axes follow in pairs
// - aux channels of stepper axes are not offered as inputs
// - irq enable takes a first-last range or mask, bit k is input k+1
// - any enabled input low diverts execution to the irq handler unless already in it
// - return resumes at saved point; stack clear discards saved point
// - eight analog inputs read by index 1 to 8, 12 or 16 bits
module gdio_port
    import gdio_pkg::*;
#(
    parameter int NUM_AXES = 8,
    parameter bit WIDE_ADC = 1'b0
) (
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire logic                   cmdValid,
    input  wire logic [3:0]             cmdOp,
    input  wire logic [IDX_W-1:0]       cmdIndex,
    input  wire logic                   cmdNeg,
    input  wire logic [IDX_W-1:0]       cmdLast,
    input  wire logic [IN_BITS-1:0]     cmdValue,
    input  wire logic [PC_W-1:0]        pcNow,
    output logic                        cmdReady,
    output logic                        rdValid,
    output logic [WORD_BITS-1:0]        rdData,
    output logic                        waitDone,
    output logic                        irqTake,
    output logic                        irqActive,
    output logic                        resumeValid,
    output logic [PC_W-1:0]             resumePc,
    output logic [GEN_OUT_BITS-1:0]     outPort,
    output logic [GEN_OUT_BITS-1:0]     outExtra,
    input  wire logic [EXT_BITS-1:0]    extPinIn,
    output logic [EXT_BITS-1:0]         extPinOut,
    output logic [EXT_BITS-1:0]         extPinOe,
    input  wire logic [GEN_IN_BITS-1:0] genIn,
    input  wire logic [AXES_MAX-1:0]    auxA,
    input  wire logic [AXES_MAX-1:0]    auxB,
    input  wire logic [AXES_MAX-1:0]    axisStepper,
    input  wire logic [ANA_CH*ANA_W-1:0] analogIn
);
    typedef struct packed {
        logic [WORD_BITS-1:0] outWord;
        logic [EXT_BITS-1:0]  extOut;
        logic [DIR_BITS-1:0]  dirCfg;
        logic [IN_BITS-1:0]   irqEn;
        logic                 inHandler;
        logic                 stackValid;
        logic [PC_W-1:0]      savedPc;
        logic                 waiting;
        logic [IDX_W-1:0]     waitIdx;
        logic                 waitHigh;
        logic                 waitDone;
        logic                 rdValid;
        logic [WORD_BITS-1:0] rdData;
        logic                 irqTake;
        logic                 resumeValid;
        logic [PC_W-1:0]      resumePc;
    } gdio_state_t;

    localparam gdio_state_t ST_RST = '{
        outWord: OUT_RST, extOut: EXT_RST, dirCfg: DIR_RST,
        irqEn: IRQ_EN_RST, inHandler: 1'b0, stackValid: 1'b0,
        savedPc: PC_RST, waiting: 1'b0, waitIdx: '0, waitHigh: 1'b0,
        waitDone: 1'b0, rdValid: 1'b0, rdData: RD_RST,
        irqTake: 1'b0, resumeValid: 1'b0, resumePc: PC_RST};

    localparam bit HAS_EXTRA = (NUM_AXES >= EXTRA_OUT_AXES);

    gdio_state_t       st;
    gdio_state_t       next_st;
    gdio_sync_if       syncBus();
    logic [AUX_BITS-1:0] auxPairs;
    logic [IN_BITS-1:0]  inLvl;
    logic                lowAny;
    logic                waitLvl;
    logic                accept;
    gdio_op_t            op;

    // level of input n after sync, output state for output blocks
    function automatic logic inLevel(input logic [IDX_W-1:0] idx,
                                     input logic [SYNC_W-1:0] sv,
                                     input logic [EXT_BITS-1:0] ext,
                                     input logic [DIR_BITS-1:0] dir,
                                     input logic [AXES_MAX-1:0] step);
        logic [IDX_W-1:0] off;
        logic             r;
        off = '0;
        r   = 1'b0;
        if (idx >= IDX_MIN && idx <= IDX_WORD_LAST) begin
            off = idx - IDX_MIN;
            r   = sv[off[3:0]];
        end else if (idx >= IDX_EXT_FIRST && idx <= IDX_EXT_LAST) begin
            off = idx - IDX_EXT_FIRST;
            r   = dir[off[4:3]] ? ext[off[4:0]]
                                : sv[SYNC_EXT_LSB + int'(off[4:0])];
        end else if (idx >= IDX_AUX_FIRST && idx <= IDX_AUX_LAST) begin
            off = idx - IDX_AUX_FIRST;
            // axis off/2, channel a on even offsets
            if (int'(off[3:1]) < NUM_AXES && !step[off[3:1]]) begin
                r = sv[SYNC_AUX_LSB + int'(off[3:0])];
            end
        end
        return r;
    endfunction

    // drive one output point; extended points only when set as output
    function automatic logic [WORD_BITS+EXT_BITS-1:0] putBit(
            input logic [IDX_W-1:0]     idx,
            input logic                 val,
            input logic [WORD_BITS-1:0] w,
            input logic [EXT_BITS-1:0]  e,
            input logic [DIR_BITS-1:0]  dir);
        logic [IDX_W-1:0] off;
        off = '0;
        if (idx >= IDX_MIN && idx <= IDX_GEN_LAST) begin
            off = idx - IDX_MIN;
            w[off[3:0]] = val;
        end else if (HAS_EXTRA && idx > IDX_GEN_LAST
                     && idx <= IDX_WORD_LAST) begin
            off = idx - IDX_MIN;
            w[off[3:0]] = val;
        end else if (idx >= IDX_EXT_FIRST && idx <= IDX_EXT_LAST) begin
            off = idx - IDX_EXT_FIRST;
            if (dir[off[4:3]]) begin
                e[off[4:0]] = val;
            end
        end
        return {e, w};
    endfunction

    // interleave aux channels: a then b per axis
    always_comb begin
        auxPairs = '0;
        for (int a = 0; a < AXES_MAX; a++) begin
            auxPairs[2*a]     = auxA[a];
            auxPairs[2*a + 1] = auxB[a];
        end
    end

    assign syncBus.raw = {auxPairs, extPinIn, genIn};

    gdio_input_sync u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .bus     (syncBus)
    );

    // levels of inputs 1 to 48 for the irq detector
    always_comb begin
        inLvl = '0;
        for (int k = 0; k < IN_BITS; k++) begin
            inLvl[k] = inLevel(IDX_W'(k + 1), syncBus.synced, st.extOut,
                               st.dirCfg, axisStepper);
        end
    end

    assign lowAny  = |(st.irqEn & ~inLvl);
    assign waitLvl = inLevel(st.waitIdx, syncBus.synced, st.extOut,
                             st.dirCfg, axisStepper);
    assign op       = gdio_op_t'(cmdOp);
    assign cmdReady = !st.waiting;
    assign accept   = cmdValid && cmdReady;

    // command execution, wait tracking and irq entry
    always_comb begin
        logic [WORD_BITS+EXT_BITS-1:0] pw;
        logic [ANA_W-1:0]              ana;
        logic [2:0]                    ch;
        pw  = '0;
        ana = '0;
        ch  = '0;
        next_st             = st;
        next_st.waitDone    = 1'b0;
        next_st.rdValid     = 1'b0;
        next_st.irqTake     = 1'b0;
        next_st.resumeValid = 1'b0;
        if (st.waiting && waitLvl == st.waitHigh) begin
            next_st.waiting  = 1'b0;
            next_st.waitDone = 1'b1;
        end
        if (accept) begin
            case (op)
                OP_SET_BIT, OP_CLR_BIT, OP_COND_BIT: begin
                    pw = putBit(cmdIndex,
                                (op == OP_SET_BIT) ||
                                (op == OP_COND_BIT && |cmdValue),
                                st.outWord, st.extOut, st.dirCfg);
                    next_st.outWord = pw[WORD_BITS-1:0];
                    next_st.extOut  = pw[WORD_BITS+EXT_BITS-1:WORD_BITS];
                end
                OP_WORD_WR: begin
                    next_st.outWord = cmdValue[WORD_BITS-1:0];
                    if (!HAS_EXTRA) begin
                        next_st.outWord[WORD_BITS-1:GEN_OUT_BITS] = '0;
                    end
                end
                OP_DIR_CFG: next_st.dirCfg = cmdValue[DIR_BITS-1:0];
                OP_READ_IN: begin
                    next_st.rdValid = 1'b1;
                    next_st.rdData  = {15'h0000,
                        inLevel(cmdIndex, syncBus.synced, st.extOut,
                                st.dirCfg, axisStepper)};
                end
                OP_WAIT_IN: begin
                    next_st.waiting  = 1'b1;
                    next_st.waitIdx  = cmdIndex;
                    next_st.waitHigh = !cmdNeg;
                end
                OP_IRQ_RANGE: begin
                    for (int k = 0; k < IN_BITS; k++) begin
                        next_st.irqEn[k] = (IDX_W'(k + 1) >= cmdIndex) &&
                                           (IDX_W'(k + 1) <= cmdLast);
                    end
                end
                OP_IRQ_MASK: next_st.irqEn = cmdValue;
                OP_IRQ_RET: begin
                    if (st.inHandler) begin
                        next_st.inHandler   = 1'b0;
                        next_st.resumeValid = st.stackValid;
                        next_st.resumePc    = st.savedPc;
                        next_st.stackValid  = 1'b0;
                    end
                end
                OP_STACK_CLR: next_st.stackValid = 1'b0;
                OP_ANA_READ: begin
                    next_st.rdValid = 1'b1;
                    if (cmdIndex >= IDX_MIN && cmdIndex <= IDX_GEN_LAST) begin
                        ch  = 3'(cmdIndex - IDX_MIN);
                        ana = analogIn[int'(ch)*ANA_W +: ANA_W];
                    end
                    // standard converter keeps the top 12 bits
                    next_st.rdData = WIDE_ADC ? ana
                        : {4'h0, ana[ANA_W-1 -: ADC_STD_BITS]};
                end
                default: next_st = next_st;
            endcase
        end
        // irq entry saves the return point and abandons any wait
        if (!st.inHandler && lowAny) begin
            next_st.irqTake    = 1'b1;
            next_st.inHandler  = 1'b1;
            next_st.stackValid = 1'b1;
            next_st.savedPc    = pcNow;
            next_st.waiting    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // pins and answers from flip-flops
    assign outPort     = st.outWord[GEN_OUT_BITS-1:0];
    assign outExtra    = st.outWord[WORD_BITS-1:GEN_OUT_BITS];
    assign extPinOut   = st.extOut;
    assign extPinOe    = {{8{st.dirCfg[3]}}, {8{st.dirCfg[2]}},
                          {8{st.dirCfg[1]}}, {8{st.dirCfg[0]}}};
    assign rdValid     = st.rdValid;
    assign rdData      = st.rdData;
    assign waitDone    = st.waitDone;
    assign irqTake     = st.irqTake;
    assign irqActive   = st.inHandler;
    assign resumeValid = st.resumeValid;
    assign resumePc    = st.resumePc;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_set_bit: assert property (
        accept && op == OP_SET_BIT && cmdIndex >= IDX_MIN
            && cmdIndex <= IDX_GEN_LAST
            |=> outPort[3'($past(cmdIndex) - IDX_MIN)])
        else $error("set bit did not drive output high");
    chk_clr_bit: assert property (
        accept && op == OP_CLR_BIT && cmdIndex >= IDX_MIN
            && cmdIndex <= IDX_GEN_LAST
            |=> !outPort[3'($past(cmdIndex) - IDX_MIN)])
        else $error("clear bit did not drive output low");
    chk_cond_bit: assert property (
        accept && op == OP_COND_BIT && cmdIndex == IDX_MIN
            |=> outPort[0] == $past(|cmdValue))
        else $error("conditional bit wrong level");
    chk_word_load: assert property (
        accept && op == OP_WORD_WR
            |=> outPort == $past(cmdValue[GEN_OUT_BITS-1:0]))
        else $error("word write not loaded");
    chk_read_level: assert property (
        accept && op == OP_READ_IN && cmdIndex == IDX_MIN
            |=> rdValid && rdData[0] == $past(syncBus.synced[0]))
        else $error("input read wrong level");
    chk_wait_stall: assert property (
        st.waiting && waitLvl != st.waitHigh && !(lowAny && !st.inHandler)
            |=> !cmdReady && !waitDone)
        else $error("wait ended before input level");
    chk_aux_stepper: assert property (
        accept && op == OP_READ_IN && cmdIndex == IDX_AUX_FIRST
            && axisStepper[0] |=> rdData[0] == 1'b0)
        else $error("stepper aux channel offered");
    chk_irq_entry: assert property (
        !st.inHandler && lowAny |=> irqTake ##1 !irqTake && irqActive)
        else $error("enabled low input not taken");
    chk_irq_resume: assert property (
        accept && op == OP_IRQ_RET && st.inHandler && st.stackValid
            |=> resumeValid && resumePc == $past(st.savedPc))
        else $error("return point not resumed");
    chk_stack_drop: assert property (
        accept && op == OP_STACK_CLR && st.inHandler
            |=> !st.stackValid)
        else $error("stack clear kept the return point");

    cov_set_bit: cover property (accept && op == OP_SET_BIT);
    cov_wait_done: cover property (waitDone);
    cov_irq_cycle: cover property (irqTake ##[1:50] resumeValid);
    cov_ana_read: cover property (accept && op == OP_ANA_READ);
endmodule
`default_nettype wire

/* File: bench/gdio_far_side.sv */
// switches, relays and encoder lines on the far side of the i/o port
`timescale 1ns/1ps
`default_nettype none
module gdio_far_side
    import gdio_pkg::*;
(
    input  wire logic [EXT_BITS-1:0]    extPinOut,
    input  wire logic [EXT_BITS-1:0]    extPinOe,
    input  wire logic [GEN_IN_BITS-1:0] swGen,
    input  wire logic [EXT_BITS-1:0]    swExt,
    input  wire logic [AXES_MAX-1:0]    swA,
    input  wire logic [AXES_MAX-1:0]    swB,
    output logic [GEN_IN_BITS-1:0]      genIn,
    output logic [EXT_BITS-1:0]         extPinIn,
    output logic [AXES_MAX-1:0]         auxA,
    output logic [AXES_MAX-1:0]         auxB
);
    // pin level: port drive wins, else the external switch
    assign extPinIn = (extPinOe & extPinOut) | (~extPinOe & swExt);
    // switches and encoder channels go straight to the inputs
    assign genIn = swGen;
    assign auxA  = swA;
    assign auxB  = swB;
endmodule
`default_nettype wire

/* File: bench/test_general_digital_io_port.sv */
// self-checking bench for the general digital i/o port
`timescale 1ns/1ps
`default_nettype none
module test_general_digital_io_port
    import gdio_pkg::*;
;
    logic          clk_sys = 1'b0;
    logic          nrst = 1'b0;
    logic          cmdValid = 1'b0;
    logic [3:0]    cmdOp = 4'h0;
    logic [6:0]    cmdIndex = 7'h00;
    logic          cmdNeg = 1'b0;
    logic [6:0]    cmdLast = 7'h00;
    logic [47:0]   cmdValue = 48'h0;
    logic [15:0]   pcNow = 16'h0000;
    logic [15:0]   swGen = 16'hffff;
    logic [31:0]   swExt = 32'hffff_ffff;
    logic [7:0]    swA = 8'h00;
    logic [7:0]    swB = 8'h00;
    logic [7:0]    axisStepper = 8'h00;
    logic [127:0]  analogIn = '0;
    wire           cmdReady, rdValid, waitDone, irqTake, irqActive;
    wire           resumeValid;
    wire [15:0]    rdData, resumePc, genIn;
    wire [7:0]     outPort, outExtra, auxA, auxB;
    wire [31:0]    extPinOut, extPinOe, extPinIn;
    logic [15:0]   outM = 16'h0000;
    logic [31:0]   extM = 32'h0;
    logic [3:0]    dirM = 4'h0;
    logic [15:0]   rdSeen;
    logic          rdvSeen, resSeen, got;
    int            bad_count = 0;
    int            cmp_count = 0;
    int            cycles = 0;
    int            k;

    gdio_port #(.NUM_AXES(8), .WIDE_ADC(1'b0)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdIndex(cmdIndex), .cmdNeg(cmdNeg),
        .cmdLast(cmdLast), .cmdValue(cmdValue), .pcNow(pcNow),
        .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
        .waitDone(waitDone), .irqTake(irqTake), .irqActive(irqActive),
        .resumeValid(resumeValid), .resumePc(resumePc),
        .outPort(outPort), .outExtra(outExtra), .extPinIn(extPinIn),
        .extPinOut(extPinOut), .extPinOe(extPinOe), .genIn(genIn),
        .auxA(auxA), .auxB(auxB), .axisStepper(axisStepper),
        .analogIn(analogIn));
    gdio_far_side far (
        .extPinOut(extPinOut), .extPinOe(extPinOe), .swGen(swGen),
        .swExt(swExt), .swA(swA), .swB(swB), .genIn(genIn),
        .extPinIn(extPinIn), .auxA(auxA), .auxB(auxB));

    // 125 MHz system clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // one command, held until taken; answer captured one edge later
    task automatic cmd(input gdio_op_t op, input logic [6:0] i,
                       input logic [47:0] v);
        cmdOp = op;
        cmdIndex = i;
        cmdValue = v;
        cmdValid = 1'b1;
        @(negedge clk_sys);
        while (cmdReady !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        #1;
        cmdValid = 1'b0;
        rdvSeen = rdValid;
        rdSeen = rdData;
        resSeen = resumeValid;
        tick(1);
    endtask

    // bit write plus the expected port image
    task automatic wr(input gdio_op_t op, input logic [6:0] i,
                      input logic [47:0] v);
        logic b;
        b = (op == OP_SET_BIT) || (op == OP_COND_BIT && v != 48'h0);
        cmd(op, i, v);
        if (i >= 1 && i <= 16) outM[i-1] = b;
        else if (i >= 17 && i <= 48 && dirM[(i-17)/8]) extM[i-17] = b;
    endtask

    task automatic outs();
        check({outExtra, outPort}, outM, "out port");
        check(extPinOut, extM, "ext out");
        check(extPinOe, {{8{dirM[3]}}, {8{dirM[2]}}, {8{dirM[1]}},
              {8{dirM[0]}}}, "ext oe");
    endtask

    task automatic hunt(input bit irq, input int lim);
        got = 1'b0;
        for (int n = 0; n < lim && !got; n++) begin
            tick(1);
            if (irq ? irqTake : waitDone) got = 1'b1;
        end
    endtask

    // expected level of an input index
    function automatic logic inLevel(input logic [6:0] i);
        if (i >= 1 && i <= 16) return swGen[i-1];
        if (i >= 17 && i <= 48)
            return dirM[(i-17)/8] ? extM[i-17] : swExt[i-17];
        if (i >= 81 && i <= 96) begin
            if (axisStepper[(i-81)/2]) return 1'b0;
            return i[0] ? swA[(i-81)/2] : swB[(i-81)/2];
        end
        return 1'b0;
    endfunction

    function automatic logic [15:0] anaExp(input int n);
        if (n < 1 || n > 8) return 16'h0000;
        return {4'h0, analogIn[(n-1)*16+4 +: 12]};
    endfunction

    // main sequence
    initial begin
        void'($urandom(32'h388d8a93));
        tick(6);
        nrst = 1'b1;
        check(cmdReady, 1'b1, "ready");
        outs();
        $display("test reset done");
        cmd(OP_DIR_CFG, 7'h00, 48'h5);
        dirM = 4'h5;
        outs();
        wr(OP_SET_BIT, 7'd16, 48'h0);
        wr(OP_SET_BIT, 7'd25, 48'h0);
        wr(OP_SET_BIT, 7'd48, 48'h0);
        outs();
        wr(OP_COND_BIT, 7'd1, 48'h4);
        outs();
        wr(OP_COND_BIT, 7'd1, 48'h0);
        outs();
        repeat (40) begin
            k = $urandom_range(1, 0);
            wr(gdio_op_t'($urandom_range(2, 0)), 7'($urandom_range(49, 0)),
               k ? {$urandom, $urandom} : 48'h0);
            outs();
        end
        repeat (3) begin
            k = $urandom;
            cmd(OP_WORD_WR, 7'h00, 48'(k[15:0]));
            outM = k[15:0];
            outs();
        end
        cmd(OP_WORD_WR, 7'h00, 48'h6);
        outM = 16'h0006;
        outs();
        $display("test outputs done");
        cmd(OP_DIR_CFG, 7'h00, 48'ha);
        dirM = 4'ha;
        swGen = $urandom;
        swExt = $urandom;
        swA = $urandom;
        swB = $urandom;
        axisStepper = $urandom;
        tick(4);
        for (int i = 0; i <= 97; i++) begin
            if (i > 49 && i < 80) continue;
            cmd(OP_READ_IN, 7'(i), 48'h0);
            check(rdvSeen, 1'b1, "read valid");
            check(rdSeen, {15'h0, inLevel(7'(i))}, "read");
        end
        axisStepper[0] = ~axisStepper[0];
        for (int i = 81; i <= 82; i++) begin
            cmd(OP_READ_IN, 7'(i), 48'h0);
            check(rdSeen, {15'h0, inLevel(7'(i))}, "aux");
        end
        swGen[0] = ~swGen[0];
        cmd(OP_READ_IN, 7'd1, 48'h0);
        check(rdSeen, {15'h0, ~swGen[0]}, "sync lag");
        tick(3);
        cmd(OP_READ_IN, 7'd1, 48'h0);
        check(rdSeen, {15'h0, swGen[0]}, "synced");
        $display("test inputs done");
        swGen[6] = 1'b0;
        swGen[5] = 1'b1;
        tick(4);
        for (int m = 0; m < 2; m++) begin
            cmdNeg = m[0];
            cmd(OP_WAIT_IN, m ? 7'd6 : 7'd7, 48'h0);
            tick(3);
            check(cmdReady, 1'b0, "stalled");
            swGen[6-m] = ~swGen[6-m];
            hunt(1'b0, 10);
            check(got, 1'b1, "wait done");
        end
        cmdNeg = 1'b0;
        $display("test wait done");
        swGen = 16'hffff;
        pcNow = $urandom;
        k = $urandom_range(15, 0);
        tick(4);
        cmd(OP_IRQ_MASK, 7'h00, 48'h1 << k);
        hunt(1'b1, 6);
        check(got, 1'b0, "no irq");
        swGen[k] = 1'b0;
        hunt(1'b1, 8);
        check(got, 1'b1, "irq mask");
        check(irqActive, 1'b1, "in handler");
        swGen[k] = 1'b1;
        tick(4);
        cmd(OP_IRQ_RET, 7'h00, 48'h0);
        check(resSeen, 1'b1, "resume");
        check(resumePc, pcNow, "resume point");
        check(irqActive, 1'b0, "left handler");
        cmdLast = 7'd5;
        cmd(OP_IRQ_RANGE, 7'd3, 48'h0);
        swGen[5] = 1'b0;
        hunt(1'b1, 6);
        check(got, 1'b0, "out of range");
        swGen[5] = 1'b1;
        swGen[3] = 1'b0;
        hunt(1'b1, 8);
        check(got, 1'b1, "irq range");
        swGen[3] = 1'b1;
        tick(4);
        cmd(OP_STACK_CLR, 7'h00, 48'h0);
        cmd(OP_IRQ_RET, 7'h00, 48'h0);
        check(resSeen, 1'b0, "dropped point");
        check(irqActive, 1'b0, "cleared");
        cmd(OP_IRQ_MASK, 7'h00, 48'h0);
        $display("test irq done");
        analogIn = {$urandom, $urandom, $urandom, $urandom};
        for (int n = 0; n <= 9; n++) begin
            cmd(OP_ANA_READ, 7'(n), 48'h0);
            check(rdSeen, anaExp(n), "analog");
        end
        $display("test analog done");
        close_out();
    end
endmodule
`default_nettype wire
